// ===== tsos_cfg.svh
// constants for the time-stamped output scheduler
`ifndef TSOS_CFG_SVH
`define TSOS_CFG_SVH
`define TSOS_OFS_STATE 2'd0
`define TSOS_OFS_SEQ 2'd1
`define TSOS_OFS_TIME 2'd2
`define TSOS_ENTRIES_SMALL 4'd5
`define TSOS_ENTRIES_LARGE 4'd15
`define TSOS_IMG_BYTES 60
`define TSOS_SEQ_LAST_BIT 6
`define TSOS_QUEUE_DEPTH 31
`define TSOS_FIFO_DEPTH 16
`define TSOS_CLK_MHZ 50
`define TSOS_TICK_NS 1000
`define TSOS_CLK_NS 20
`define TSOS_TICK_CYCLES (`TSOS_TICK_NS / `TSOS_CLK_NS)
`define TSOS_STS_OK 8'h00
`define TSOS_STS_MISMATCH 8'h01
`define TSOS_STS_NONEW 8'h02
`define TSOS_STS_FULL 8'h03
`define TSOS_STS_LASTFLAG 8'h80
`define TSOS_LAST_ID 8'h40
`define TSOS_NEXT_ID 8'hC0
`endif

// ===== tsos_pkg.sv
// types used by the scheduler top module
package tsos_pkg;
  typedef logic [31:0] tsos_entry_t;
  typedef enum logic [1:0] {TSOS_IDLE, TSOS_SCAN} tsos_scan_t;
endpackage

// ===== tsos_fifo.sv
// generic flip-flop fifo with valid/ready on both sides
module tsos_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready = (cnt_q != ($clog2(DEPTH+1))'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign o_count = cnt_q;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage, no reset needed on data
  always_ff @(posedge i_clock)
  begin
    if (i_enable && push)
      mem_q[wr_q] <= i_in_data;
  end

  // pointers and fill count
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (i_enable)
    begin
      if (push)
        wr_q <= bump(wr_q);
      if (pop)
        rd_q <= bump(rd_q);
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ===== tsos_top.sv
// time-stamped output scheduler: image intake, queue and timed execution
`include "tsos_cfg.svh"
module tsos_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_large_image,
  input wire logic i_img_we,
  input wire logic [5:0] i_img_addr,
  input wire logic [7:0] i_img_wdata,
  input wire logic i_img_commit,
  output logic [3:0] o_do_level,
  output logic [3:0] o_do_enable,
  output logic [7:0] o_last_accepted_seq,
  output logic [7:0] o_next_pending_seq,
  output logic [7:0] o_queue_state_code,
  output logic [7:0] o_queue_fill_count,
  output logic [31:0] o_edge_time_stamp
);
  // output image, written byte by byte by the host side
  logic [7:0] img_q [`TSOS_IMG_BYTES];
  // scan of the image after a commit
  tsos_pkg::tsos_scan_t scan_q;
  logic [3:0] idx_q;
  logic [3:0] n_entries;
  logic [5:0] expect_q;
  logic [5:0] last_seq_q;
  logic [5:0] next_seq_q;
  logic [7:0] sts_q;
  logic any_new_q;
  logic [4:0] count_q;
  logic [4:0] flag_cnt_q;
  logic [31:0] us_q;
  logic [5:0] div_q;
  logic [3:0] level_q;
  logic [3:0] en_q;
  // entry under scan and head-of-queue entry
  logic [7:0] cur_state;
  logic [7:0] cur_seq;
  logic [15:0] cur_time;
  logic [7:0] hd_state;
  logic [7:0] hd_seq;
  logic [15:0] hd_time;
  logic [5:0] base;
  logic entry_ok;
  logic push_v;
  logic push_rdy;
  logic head_v;
  logic fire;
  logic [4:0] fifo_cnt;
  tsos_pkg::tsos_entry_t head_w;

  // byte address of entry k, field f
  function automatic logic [5:0] eaddr(input logic [3:0] k, input logic [1:0] f);
    eaddr = {k, 2'b00} + {4'h0, f};
  endfunction

  assign n_entries = i_large_image ? `TSOS_ENTRIES_LARGE : `TSOS_ENTRIES_SMALL;
  assign base = eaddr(idx_q, `TSOS_OFS_STATE);
  // field extraction at fixed entry offsets
  assign cur_state = img_q[base];
  assign cur_seq = img_q[eaddr(idx_q, `TSOS_OFS_SEQ)];
  assign cur_time = {img_q[eaddr(idx_q, `TSOS_OFS_TIME) + 6'h01],
                     img_q[eaddr(idx_q, `TSOS_OFS_TIME)]};
  // an entry is valid if reserved bits clear and number is the expected one
  assign entry_ok = (cur_state[3:0] == 4'h0) && (cur_seq[7] == 1'b0)
                    && (cur_seq[5:0] == expect_q);
  assign push_v = (scan_q == tsos_pkg::TSOS_SCAN) && entry_ok
                  && (count_q != 5'(`TSOS_QUEUE_DEPTH));

  // image write port
  always_ff @(posedge i_clock)
  begin
    if (i_enable && i_img_we && (i_img_addr < 6'(`TSOS_IMG_BYTES)))
      img_q[i_img_addr] <= i_img_wdata;
  end

  // walk the image once per commit, stop after a last-marked entry
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      scan_q <= tsos_pkg::TSOS_IDLE;
      idx_q <= 4'h0;
    end
    else if (i_enable)
    begin
      unique case (scan_q)
        tsos_pkg::TSOS_IDLE:
        begin
          if (i_img_commit)
          begin
            scan_q <= tsos_pkg::TSOS_SCAN;
            idx_q <= 4'h0;
          end
        end
        tsos_pkg::TSOS_SCAN:
        begin
          // a full queue refuses the entry, so the rest cannot follow either
          if (entry_ok && !push_rdy)
            scan_q <= tsos_pkg::TSOS_IDLE;
          else if ((entry_ok && cur_seq[`TSOS_SEQ_LAST_BIT])
                   || (idx_q == n_entries - 4'h1))
            scan_q <= tsos_pkg::TSOS_IDLE;
          else
            idx_q <= idx_q + 4'h1;
        end
      endcase
    end
  end

  // expected number, last accepted and state code
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      expect_q <= 6'h01;
      last_seq_q <= 6'h00;
      sts_q <= `TSOS_STS_NONEW;
      any_new_q <= 1'b0;
    end
    else if (i_enable)
    begin
      if (i_img_commit && scan_q == tsos_pkg::TSOS_IDLE)
        any_new_q <= 1'b0;
      if (push_v && push_rdy)
      begin
        expect_q <= cur_seq[5:0] + 6'h01;
        last_seq_q <= cur_seq[5:0];
        any_new_q <= 1'b1;
        sts_q <= `TSOS_STS_OK;
      end
      else if (scan_q == tsos_pkg::TSOS_SCAN && entry_ok)
        sts_q <= `TSOS_STS_FULL;
      // first entry decides between a numbering fault and a stale image
      else if (scan_q == tsos_pkg::TSOS_SCAN && idx_q == 4'h0 && !entry_ok)
        sts_q <= (cur_seq[5:0] != last_seq_q) ? `TSOS_STS_MISMATCH : `TSOS_STS_NONEW;
      // a mismatch seen this scan must not be hidden by the end of the walk
      else if (scan_q == tsos_pkg::TSOS_SCAN && !any_new_q && sts_q != `TSOS_STS_MISMATCH
               && idx_q == n_entries - 4'h1)
        sts_q <= `TSOS_STS_NONEW;
    end
  end

  // queue, 16 words in flip-flops
  tsos_fifo #(
    .WIDTH(32),
    .DEPTH(`TSOS_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(i_enable),
    .i_in_valid(push_v),
    .o_in_ready(push_rdy),
    .i_in_data({cur_state, cur_seq, cur_time}),
    .o_out_valid(head_v),
    .i_out_ready(fire),
    .o_out_data(head_w),
    .o_count(fifo_cnt)
  );

  assign hd_state = head_w[31:24];
  assign hd_seq = head_w[23:16];
  assign hd_time = head_w[15:0];
  assign fire = head_v && (us_q[15:0] == hd_time);

  // microsecond tick divider and free running counter
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      div_q <= 6'h00;
      us_q <= 32'h0000_0000;
    end
    else if (i_enable)
    begin
      if (div_q == 6'(`TSOS_TICK_CYCLES - 1))
      begin
        div_q <= 6'h00;
        us_q <= us_q + 32'h0000_0001; // wraps naturally
      end
      else
        div_q <= div_q + 6'h01;
    end
  end

  // outputs take the head entry when its time arrives
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      level_q <= 4'h0;
      en_q <= 4'h0;
    end
    else if (i_enable && fire)
    begin
      level_q <= {hd_state[4], hd_state[5], hd_state[6], hd_state[7]};
      en_q <= {hd_state[4], hd_state[5], hd_state[6], hd_state[7]};
    end
  end

  // fill count, next pending number and last-flag tracking
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      count_q <= 5'h00;
      next_seq_q <= 6'h01;
      flag_cnt_q <= 5'h00;
    end
    else if (i_enable)
    begin
      count_q <= fifo_cnt + 5'((push_v && push_rdy) ? 1 : 0) - 5'(fire ? 1 : 0);
      if (fire)
        next_seq_q <= hd_seq[5:0] + 6'h01;
      else if (count_q == 5'h00 && push_v && push_rdy)
        next_seq_q <= cur_seq[5:0];
      if ((push_v && push_rdy && cur_seq[`TSOS_SEQ_LAST_BIT])
          && !(fire && hd_seq[`TSOS_SEQ_LAST_BIT]))
        flag_cnt_q <= flag_cnt_q + 5'h01;
      else if (!(push_v && push_rdy && cur_seq[`TSOS_SEQ_LAST_BIT])
               && fire && hd_seq[`TSOS_SEQ_LAST_BIT])
        flag_cnt_q <= flag_cnt_q - 5'h01;
    end
  end

  // registered status and pins
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_do_level <= 4'h0;
      o_do_enable <= 4'h0;
      o_last_accepted_seq <= `TSOS_LAST_ID;
      o_next_pending_seq <= `TSOS_NEXT_ID;
      o_queue_state_code <= `TSOS_STS_NONEW;
      o_queue_fill_count <= 8'h00;
      o_edge_time_stamp <= 32'h0000_0000;
    end
    else if (i_enable)
    begin
      o_do_level <= level_q;
      o_do_enable <= en_q;
      o_last_accepted_seq <= `TSOS_LAST_ID | {2'b00, last_seq_q};
      o_next_pending_seq <= `TSOS_NEXT_ID | {2'b00, next_seq_q};
      o_queue_state_code <= sts_q | ((flag_cnt_q != 5'h00) ? `TSOS_STS_LASTFLAG : 8'h00);
      o_queue_fill_count <= {3'b000, count_q};
      o_edge_time_stamp <= us_q;
    end
  end
endmodule

// ===== tsos_props.sv
// port-level assertions for the scheduler top
module tsos_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [3:0] o_do_level,
  input wire logic [3:0] o_do_enable,
  input wire logic [7:0] o_last_accepted_seq,
  input wire logic [7:0] o_next_pending_seq,
  input wire logic [7:0] o_queue_state_code,
  input wire logic [7:0] o_queue_fill_count,
  input wire logic [31:0] o_edge_time_stamp
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // identification bits of both sequence status bytes
  last_id_a: assert property (o_last_accepted_seq[7:6] == 2'b01)
    else $error("last seq id bits wrong");
  next_id_a: assert property (o_next_pending_seq[7:6] == 2'b11)
    else $error("next seq id bits wrong");
  code_range_a: assert property (o_queue_state_code[6:0] <= 7'h03)
    else $error("state code out of range");
  fill_max_a: assert property (o_queue_fill_count <= 8'h10)
    else $error("fill above queue depth");
  // fill count moves one entry at a time
  fill_step_a: assert property ($changed(o_queue_fill_count) |->
    o_queue_fill_count == $past(o_queue_fill_count) + 8'h01 ||
    o_queue_fill_count == $past(o_queue_fill_count) - 8'h01)
    else $error("fill count jumped");
  // counter wraps naturally through 32-bit add
  tick_inc_a: assert property ($changed(o_edge_time_stamp) |->
    o_edge_time_stamp == $past(o_edge_time_stamp) + 32'h1)
    else $error("counter step wrong");
  tick_rate_a: assert property (disable iff (!i_rst_n || !i_enable)
    $changed(o_edge_time_stamp) |-> ##[49:51] $changed(o_edge_time_stamp))
    else $error("counter tick period wrong");
  chan_enable_a: assert property (o_do_enable == o_do_level)
    else $error("enable differs from level");
endmodule
bind tsos_top tsos_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(i_enable),
  .o_do_level(o_do_level), .o_do_enable(o_do_enable),
  .o_last_accepted_seq(o_last_accepted_seq), .o_next_pending_seq(o_next_pending_seq),
  .o_queue_state_code(o_queue_state_code), .o_queue_fill_count(o_queue_fill_count),
  .o_edge_time_stamp(o_edge_time_stamp));

// ===== tsos_host.sv
// host model that fills the output image and commits it
module tsos_host (
  input wire logic i_clock,
  output logic o_img_we,
  output logic [5:0] o_img_addr,
  output logic [7:0] o_img_wdata,
  output logic o_img_commit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] img [60];
  // idle bus at time zero
  initial
  begin
    o_img_we = 1'b0;
    o_img_addr = 6'h00;
    o_img_wdata = 8'h00;
    o_img_commit = 1'b0;
  end
  // entry k: state, sequence, time low, time high
  task automatic put(input int k, input logic [7:0] st, sq, input logic [15:0] tm);
    img[4*k] = st;
    img[4*k+1] = sq;
    img[4*k+2] = tm[7:0];
    img[4*k+3] = tm[15:8];
  endtask
  // whole image every time, so no stale tail entry is left behind
  task automatic send(input int n);
    for (int i = 0; i < 4*n; i++)
    begin
      @(negedge i_clock);
      o_img_we = 1'b1;
      o_img_addr = 6'(i);
      o_img_wdata = img[i];
    end
    @(negedge i_clock);
    o_img_we = 1'b0;
    o_img_wdata = ~o_img_wdata;
    o_img_commit = 1'b1;
    @(negedge i_clock);
    o_img_commit = 1'b0;
    repeat (20) @(negedge i_clock); // scan plus status lag
  endtask
endmodule

// ===== tsos_top_tb.sv
// self-checking bench for the time-stamped output scheduler
module tsos_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  int mismatches, total_checks;
  logic clk, rst_n, big, we, commit, ena;
  logic [5:0] addr;
  logic [7:0] wdata, last, next, code, fill;
  logic [3:0] level, en;
  logic [31:0] ts;
  logic [15:0] tb0;
  tsos_top dut (.i_clock(clk), .i_rst_n(rst_n), .i_enable(ena), .i_large_image(big),
    .i_img_we(we), .i_img_addr(addr), .i_img_wdata(wdata), .i_img_commit(commit),
    .o_do_level(level), .o_do_enable(en), .o_last_accepted_seq(last),
    .o_next_pending_seq(next), .o_queue_state_code(code), .o_queue_fill_count(fill),
    .o_edge_time_stamp(ts));
  tsos_host host (.i_clock(clk), .o_img_we(we), .o_img_addr(addr), .o_img_wdata(wdata),
    .o_img_commit(commit));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic stat(input logic [7:0] l, c, f);
    cmp("last", l, last);
    cmp("code", c, code);
    cmp("fill", f, fill);
  endtask
  // bounded wait for a fill level
  task automatic wait_fill(input logic [7:0] v);
    for (int n = 0; fill !== v; n++)
    begin
      @(negedge clk);
      if (n > 5000)
      begin
        cmp("fill wait", v, fill);
        test_done();
      end
    end
  endtask
  task automatic t_reset;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    stat(8'h40, 8'h02, 8'h00);
    cmp("next", 8'hC1, next);
    cmp("time", 8'h00, ts[7:0]);
  endtask
  // entry 3 follows a last-marked entry and must be dropped
  task automatic t_run;
    big = 1'b0;
    tb0 = ts[15:0];
    host.put(0, 8'hA0, 8'h01, tb0 + 16'h0014);
    host.put(1, 8'h50, 8'h02, tb0 + 16'h001E);
    host.put(2, 8'hF0, 8'h43, tb0 + 16'h0028);
    host.put(3, 8'h10, 8'h04, tb0 + 16'h0030);
    host.put(4, 8'h20, 8'h05, tb0 + 16'h0032);
    host.send(5);
    stat(8'h43, 8'h80, 8'h03);
    wait_fill(8'h02);
    cmp("time", 8'h14, 8'(ts[15:0] - tb0));
    repeat (4) @(negedge clk);
    cmp("level", 8'h05, {4'h0, level});
    cmp("enable", 8'h05, {4'h0, en});
    wait_fill(8'h01);
    repeat (4) @(negedge clk);
    cmp("level", 8'h0A, {4'h0, level});
    wait_fill(8'h00);
    repeat (4) @(negedge clk);
    cmp("level", 8'h0F, {4'h0, level});
    cmp("enable", 8'h0F, {4'h0, en});
    cmp("next", 8'hC4, next);
  endtask
  task automatic t_refuse;
    for (int k = 1; k < 5; k++)
      host.put(k, 8'h01, 8'h7F, 16'h0000);
    host.put(0, 8'hA1, 8'h04, 16'h0000);
    host.send(5);
    cmp("fill", 8'h00, fill);
    host.put(0, 8'hA0, 8'h05, 16'h0000);
    host.send(5);
    stat(8'h43, 8'h01, 8'h00);
  endtask
  // far-future times keep everything queued
  task automatic t_full;
    big = 1'b1;
    tb0 = ts[15:0] + 16'h7530;
    for (int k = 0; k < 15; k++)
      host.put(k, 8'h80, 8'(k + 4), tb0);
    host.send(15);
    stat(8'h52, 8'h00, 8'h0F);
    host.send(15);
    stat(8'h52, 8'h01, 8'h0F);
    host.put(0, 8'h80, 8'h13, tb0);
    host.put(1, 8'h80, 8'h14, tb0);
    host.send(15);
    stat(8'h53, 8'h03, 8'h10);
  endtask
  // clock enable low must freeze the counter and the queue
  task automatic t_hold;
    logic [7:0] h;
    h = ts[7:0];
    ena = 1'b0;
    repeat (120) @(negedge clk);
    cmp("frozen time", h, ts[7:0]);
    cmp("frozen fill", 8'h10, fill);
    ena = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  initial
  begin
    mismatches = 0;
    total_checks = 0;
    big = 1'b0;
    ena = 1'b1;
    t_reset();
    t_run();
    t_refuse();
    t_full();
    t_hold();
    t_reset();
    test_done();
  end
endmodule
